// [ascs_top.sv]
// result FIFO and serial conversion sequencer of a 12-bit converter
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// result FIFO
// ----------------------------------------------------------------
module ascs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wp_ff;
   logic [AW:0]      rp_ff;
   wire              push_w = in_valid_i & in_ready_o;
   wire              pop_w  = out_valid_o & out_ready_i;

   // honest full and empty from pointer wrap bit
   assign in_ready_o  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
   assign out_valid_o = wp_ff != rp_ff;
   assign out_data_o  = mem_ff[rp_ff[AW-1:0]];

   // storage write
   always_ff @(posedge clk_i)
      if (push_w)
         mem_ff[wp_ff[AW-1:0]] <= in_data_i;

   // pointers
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
      end
      else
      begin
         wp_ff <= wp_ff + (AW+1)'(push_w);
         rp_ff <= rp_ff + (AW+1)'(pop_w);
      end
endmodule

// ----------------------------------------------------------------
// sequencer top
// ----------------------------------------------------------------
module ascs_top
   import ascs_pkg::*;
#(
   parameter int NUM_CH     = 16,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // serial port pins
   input  wire logic        cs_n_i,
   input  wire logic        sclk_i,
   input  wire logic        din_i,
   output logic             dout_o,
   output logic             dout_oe_o,
   output logic             eoc_n_o,
   // converter core
   output logic             adc_pwr_o,
   output logic             adc_start_o,
   output logic [3:0]       adc_chan_o,
   output logic             adc_temp_o,
   input  wire logic        adc_done_i,
   input  wire logic [11:0] adc_data_i,
   // status
   output logic [1:0]       clk_mode_o
);
   import ascs_pkg::*;
   initial if (NUM_CH < 1 || NUM_CH > 16) $error("channel count out of range");

   // ----------------------------------------------------------------
   // pin synchronisers: three stages, change taken when 2 and 3 agree
   // ----------------------------------------------------------------
   logic [2:0] s1_ff, s2_ff, s3_ff, st_ff;
   wire  [2:0] pins_w = {cs_n_i, sclk_i, din_i};
   wire  [2:0] agree_w = ~(s2_ff ^ s3_ff);
   wire  [2:0] nxt_st = (st_ff & ~agree_w) | (s3_ff & agree_w);
   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         s1_ff <= 3'h7;
         s2_ff <= 3'h7;
         s3_ff <= 3'h7;
         st_ff <= 3'h7;
      end
      else
      begin
         s1_ff <= pins_w;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         st_ff <= nxt_st;
      end

   wire cs_fall_w = st_ff[2] & ~nxt_st[2];
   wire cs_rise_w = ~st_ff[2] & nxt_st[2];
   wire cs_low_w  = ~st_ff[2];
   wire sck_rise  = cs_low_w & ~st_ff[1] & nxt_st[1];
   wire sck_fall  = cs_low_w & st_ff[1] & ~nxt_st[1];
   wire din_w     = nxt_st[0];

   // ----------------------------------------------------------------
   // byte receiver and register writes
   // ----------------------------------------------------------------
   logic [2:0] bit_ff;
   logic [6:0] sr_ff;
   logic [1:0] ck_ff;
   logic [3:0] chan_ff;
   logic [1:0] scan_ff;
   logic       treq_ff;
   wire  [7:0] byte_w   = {sr_ff, din_w};
   wire        byte_end = sck_rise & (bit_ff == 3'h7);
   wire        conv_wr  = byte_end & byte_w[7];
   wire        is_setup = sr_ff[1:0] == 2'h1;
   // setup bits written one by one as they arrive, so a cut write keeps older bits
   wire        ck1_wr   = sck_rise & (bit_ff == 3'h2) & is_setup;
   wire        ck0_wr   = sck_rise & (bit_ff == 3'h3) & (sr_ff[2:1] == 2'h1);
   wire        mode10_w = ck_ff == CK_INT_SER;
   wire        mode11_w = ck_ff == CK_EXT_SER;

   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         bit_ff <= 3'h0;
         sr_ff  <= 7'h00;
      end
      else if (cs_fall_w)
         bit_ff <= 3'h0;
      else if (sck_rise)
      begin
         bit_ff <= bit_ff + 3'h1;
         sr_ff  <= byte_w[6:0];
      end

   // clock mode after reset is the internal serial-started mode
   always_ff @(posedge core_clk_i)
      if (rst_i)
         ck_ff <= CK_RESET;
      else
      begin
         if (ck1_wr)
            ck_ff[1] <= din_w;
         if (ck0_wr)
            ck_ff[0] <= din_w;
      end

   // ----------------------------------------------------------------
   // scan sequencer
   // ----------------------------------------------------------------
   ascs_state_e st_q;
   logic [7:0] wake_ff;
   logic [3:0] cur_ff, last_ff;
   logic [1:0] rep_ff;
   logic       tpend_ff, m11_ff, m11t_ff, one_ff;
   logic [11:0] res_ff;
   logic       f_ready;
   wire        idle_w  = st_q == ST_IDLE;
   wire [3:0]  top_w   = 4'(NUM_CH - 1);
   wire        last_w  = ~tpend_ff & (cur_ff == last_ff) & (rep_ff == 2'h0);

   // conversion byte fields are latched while idle, in every clock mode
   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         chan_ff <= 4'h0;
         scan_ff <= 2'h0;
         treq_ff <= 1'b0;
      end
      else if (conv_wr && idle_w)
      begin
         chan_ff <= byte_w[6:3];
         scan_ff <= byte_w[2:1];
         treq_ff <= byte_w[0];
      end

   // state register and per-scan bookkeeping
   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         st_q     <= ST_IDLE;
         wake_ff  <= 8'h00;
         cur_ff   <= 4'h0;
         last_ff  <= 4'h0;
         rep_ff   <= 2'h0;
         tpend_ff <= 1'b0;
         one_ff   <= 1'b0;
         res_ff   <= 12'h000;
      end
      else
         case (st_q)
            ST_IDLE:
               if (conv_wr && (mode10_w || mode11_w))
               begin
                  // requested temperature always converted first
                  tpend_ff <= byte_w[0];
                  one_ff   <= mode11_w;
                  wake_ff  <= 8'(WAKE_CYC - 1);
                  // mode 11 drops scanning: one result, of channel N, or of the temperature when requested
                  cur_ff   <= (!mode11_w && byte_w[2:1] == SCAN_LOW_TO_N) ? 4'h0 : byte_w[6:3];
                  last_ff  <= (!mode11_w && byte_w[2:1] == SCAN_N_TO_TOP) ? top_w : byte_w[6:3];
                  rep_ff   <= (!mode11_w && byte_w[2:1] == SCAN_N_REPEAT) ?
                              2'(SCAN_REPEATS - 1) : 2'h0;
                  st_q     <= mode11_w ? ST_REQ : ST_WAKE;
               end
            ST_WAKE:
               if (wake_ff == 8'h00)
                  st_q <= ST_REQ;
               else
                  wake_ff <= wake_ff - 8'h01;
            ST_REQ:
               st_q <= ST_WAIT;
            ST_WAIT:
               if (adc_done_i)
               begin
                  res_ff <= adc_data_i;
                  st_q   <= one_ff ? ST_IDLE : ST_PUSH;
               end
            ST_PUSH:
               // waits here while the FIFO is full
               if (f_ready)
               begin
                  if (tpend_ff)
                     tpend_ff <= 1'b0;
                  else if (rep_ff != 2'h0)
                     rep_ff <= rep_ff - 2'h1;
                  else
                     cur_ff <= cur_ff + 4'h1;
                  st_q <= last_w ? ST_DONE : ST_REQ;
               end
            ST_DONE:
               st_q <= ST_IDLE;
            default:
               st_q <= ST_IDLE;
         endcase

   // converter core drive, registered
   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         adc_start_o <= 1'b0;
         adc_chan_o  <= 4'h0;
         adc_temp_o  <= 1'b0;
         adc_pwr_o   <= 1'b0;
      end
      else
      begin
         adc_start_o <= st_q == ST_REQ;
         adc_chan_o  <= cur_ff;
         adc_temp_o  <= tpend_ff;
         adc_pwr_o   <= ~idle_w;
      end

   // ----------------------------------------------------------------
   // result FIFO
   // ----------------------------------------------------------------
   logic        f_valid, pop_w;
   logic [15:0] f_data;
   wire         push_w = st_q == ST_PUSH;
   wire  [15:0] entry_w = {LEAD_ZEROS'(0), res_ff};
   ascs_fifo #(
      .WIDTH (ENTRY_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (core_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_w),
      .in_ready_o  (f_ready),
      .in_data_i   (entry_w),
      .out_valid_o (f_valid),
      .out_ready_i (pop_w),
      .out_data_o  (f_data)
   );

   // ----------------------------------------------------------------
   // conversion-done flag: completion wins over a same-cycle release
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
      if (rst_i)
         eoc_n_o <= 1'b1;
      else if (st_q == ST_DONE)
         eoc_n_o <= 1'b0;
      else if (cs_fall_w)
         eoc_n_o <= 1'b1;

   // ----------------------------------------------------------------
   // mode 11 output window, counted in serial clock falls
   // ----------------------------------------------------------------
   logic [7:0] mcnt_ff;
   wire  [7:0] mend_w   = m11t_ff ? 8'(TEMP_CLKS) : 8'(M11_CLKS);
   wire  [7:0] mstart_w = m11t_ff ? 8'(TEMP_CLKS - TEMP_OUT_CLKS) : 8'h00;
   wire  [7:0] moff_w   = mcnt_ff - mstart_w;
   // index the whole 16-bit entry so the four lead zeros never fall outside the result
   wire        m11_bit  = (mcnt_ff >= mstart_w) ? entry_w[4'(15 - moff_w[3:0])] : 1'b0;
   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         m11_ff  <= 1'b0;
         m11t_ff <= 1'b0;
         mcnt_ff <= 8'h00;
      end
      else if (conv_wr && idle_w && mode11_w)
      begin
         m11_ff  <= 1'b1;
         m11t_ff <= byte_w[0];
         // the fall that closes the conversion byte wraps this to zero
         mcnt_ff <= 8'hFF;
      end
      else if (m11_ff && sck_fall)
      begin
         mcnt_ff <= mcnt_ff + 8'h01;
         if (mcnt_ff + 8'h01 == mend_w)
            m11_ff <= 1'b0;
      end

   // ----------------------------------------------------------------
   // FIFO read-out with partial-read handling
   // ----------------------------------------------------------------
   logic [4:0] idx_ff, end_ff;
   wire        rd_on   = f_valid & ~m11_ff;
   wire        step_w  = rd_on & sck_fall;
   wire        whole_w = step_w & (idx_ff + 5'h01 == end_ff);
   wire        cut1_w  = rd_on & cs_rise_w & (idx_ff != 5'h00) & (idx_ff < 5'(BYTE_BITS));
   wire        cut2_w  = rd_on & cs_rise_w & (idx_ff > 5'(BYTE_BITS));
   assign pop_w = whole_w | cut2_w;
   always_ff @(posedge core_clk_i)
      if (rst_i)
      begin
         idx_ff <= 5'h00;
         end_ff <= 5'(ENTRY_BITS);
      end
      else if (pop_w)
      begin
         idx_ff <= 5'h00;
         end_ff <= 5'(ENTRY_BITS);
      end
      else if (cut1_w)
         end_ff <= idx_ff + 5'(BYTE_BITS);
      else if (step_w)
         idx_ff <= idx_ff + 5'h01;

   // serial data out, registered; reads as zero when nothing is queued, except in the mode 11 window where m11_bit drives it
   wire  fifo_bit = f_valid ? f_data[4'(15 - idx_ff[3:0])] : 1'b0;
   always_ff @(posedge core_clk_i)
      if (rst_i)
         dout_o <= 1'b0;
      else
         dout_o <= m11_ff ? m11_bit : fifo_bit;
   assign dout_oe_o  = cs_low_w;
   assign clk_mode_o = ck_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_RESET_MODE: assert property (@(posedge core_clk_i) rst_i |=> ck_ff == CK_INT_SER)
      else $error("clock mode not internal serial after reset");
   AST_SCAN_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
      conv_wr && idle_w && mode10_w |=> st_q == ST_WAKE ##[1:300] st_q == ST_REQ)
      else $error("mode 10 byte did not start a scan");
   AST_PWR_SCAN: assert property (@(posedge core_clk_i) disable iff (rst_i)
      st_q == ST_WAKE |=> adc_pwr_o)
      else $error("core not powered during scan");
   AST_EOC_DONE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      st_q == ST_DONE |=> !eoc_n_o && !f_valid == 1'b0)
      else $error("scan end without conversion-done or results");
   AST_TEMP_FIRST: assert property (@(posedge core_clk_i) disable iff (rst_i)
      st_q == ST_REQ && tpend_ff |=> adc_start_o && adc_temp_o)
      else $error("temperature not converted first");
   AST_EOC_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !eoc_n_o && !cs_fall_w |=> !eoc_n_o)
      else $error("conversion-done released without chip select");
   AST_EOC_REL: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cs_fall_w && st_q != ST_DONE |=> eoc_n_o)
      else $error("conversion-done not released by chip select");
   AST_M11_ONE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      conv_wr && idle_w && mode11_w |=> m11_ff && st_q == ST_REQ ##1 st_q == ST_WAIT)
      else $error("mode 11 byte did not start a single conversion");
   AST_CUT_FIRST: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cut1_w && !pop_w |=> end_ff == $past(idx_ff) + 5'h08)
      else $error("cut first byte not continued");
   AST_CUT_SECOND: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cut2_w |=> idx_ff == 5'h00 && end_ff == 5'h10)
      else $error("cut second byte did not drop entry");
   AST_PART_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ck1_wr |=> ck_ff[1] == $past(din_w) && ck_ff[0] == $past(ck_ff[0]))
      else $error("partial setup write disturbed older bits");
   AST_LEAD_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
      push_w |-> entry_w[15:12] == 4'h0 && entry_w[11:0] == res_ff)
      else $error("FIFO entry layout wrong");
endmodule
`default_nettype wire

// [ascs_pkg.sv]
// constants and types for the serial conversion sequencer
//
// Notes on behaviour
// - clock mode 10: a conversion byte starts an automatic scan on the internal timebase.
// - clock mode 10 is selected after reset until software changes it.
// - mode 10 scan powers up, converts each requested channel, fills FIFO, shuts down.
// - finished scan drives conversion-done low; results then readable from the FIFO.
// - a requested temperature result enters the FIFO ahead of all channel results.
// - mode 10 conversion-done stays low until chip select next falls.
// - clock mode 11: one conversion per conversion byte, timed by serial clock.
// - mode 11 inhibits scanning and averaging; result shifts out during conversion.
// - mode 11 temperature result appears during the final two zero bytes.
// - first byte cut short: next byte continues with following 8 bits; rest dropped.
// - second byte cut short: remainder of that entry is dropped.
// - other entries stay intact after a partial read; host ignores 4 lead bits.
// - partial register write updates bits from MSB down; other bits keep old value.
// - results straight binary, VREF/4096 per step; temperature 0.125 C per step.
`default_nettype none
package ascs_pkg;
   // clock mode encodings of the setup byte
   localparam logic [1:0] CK_CNVST_SCAN = 2'h0;
   localparam logic [1:0] CK_CNVST_ONE  = 2'h1;
   localparam logic [1:0] CK_INT_SER    = 2'h2;
   localparam logic [1:0] CK_EXT_SER    = 2'h3;
   localparam logic [1:0] CK_RESET      = CK_INT_SER;
   // scan mode encodings of the conversion byte
   localparam logic [1:0] SCAN_LOW_TO_N = 2'h0;
   localparam logic [1:0] SCAN_N_TO_TOP = 2'h1;
   localparam logic [1:0] SCAN_N_REPEAT = 2'h2;
   localparam logic [1:0] SCAN_N_ONLY   = 2'h3;
   localparam int         SCAN_REPEATS  = 4;
   // serial byte and entry layout
   localparam int         BYTE_BITS     = 8;
   localparam int         ENTRY_BITS    = 16;
   localparam int         LEAD_ZEROS    = 4;
   // mode 11 frame lengths in serial clocks
   localparam int         M11_CLKS      = 16;
   localparam int         TEMP_CLKS     = 192;
   localparam int         TEMP_OUT_CLKS = 16;
   // internal timebase
   localparam int         CLK_NS        = 40;
   localparam int         T_WAKE_NS     = 1000;
   localparam int         WAKE_CYC      = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_WAKE = 6'h02,
      ST_REQ  = 6'h04,
      ST_WAIT = 6'h08,
      ST_PUSH = 6'h10,
      ST_DONE = 6'h20
   } ascs_state_e;
endpackage
`default_nettype wire

// [ascs_host.sv]
// serial host model driving chip select, serial clock and data in
`timescale 1ns/1ns
`default_nettype none
module ascs_host (
   // core clock paces the link
   input  wire logic clk_i,
   // serial pins
   input  wire logic dout_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      din_o
);
   // idle pins: chip select high, serial clock parked low
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o  = 1'b0;
   end

   // lower chip select; settle time covers the pin synchroniser
   task automatic frame_on();
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (8) @(negedge clk_i);
   endtask

   // raise chip select; released data line flips so stale bits never pass
   task automatic frame_off();
      repeat (8) @(negedge clk_i);
      cs_n_o = 1'b1;
      din_o  = ~din_o;
      repeat (8) @(negedge clk_i);
   endtask

   // n bits msb first, 320 ns a bit; dout taken late in the high phase
   task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         din_o = tx[15-i];
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b1;
         repeat (4) @(negedge clk_i);
         rx = {rx[14:0], dout_i};
         sclk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the serial conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import ascs_pkg::*;
   // clock, reset and pins
   logic        core_clk_i;
   logic        rst_i;
   logic        cs_n_i;
   logic        sclk_i;
   logic        din_i;
   logic        dout_o;
   logic        dout_oe_o;
   logic        eoc_n_o;
   logic        adc_pwr_o;
   logic        adc_start_o;
   logic [3:0]  adc_chan_o;
   logic        adc_temp_o;
   logic        adc_done_i;
   logic [11:0] adc_data_i;
   logic [1:0]  clk_mode_o;
   // converter model and bookkeeping
   logic [2:0]  dly;
   logic [7:0]  seq;
   logic [11:0] res;
   logic [11:0] exp_q[$];
   logic [15:0] rx;
   logic [15:0] e;
   int          n_mismatch;
   int          checks;

   ascs_top #(.NUM_CH(16), .FIFO_DEPTH(8)) u_ascs_top (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cs_n_i     (cs_n_i),
      .sclk_i     (sclk_i),
      .din_i      (din_i),
      .dout_o     (dout_o),
      .dout_oe_o  (dout_oe_o),
      .eoc_n_o    (eoc_n_o),
      .adc_pwr_o  (adc_pwr_o),
      .adc_start_o(adc_start_o),
      .adc_chan_o (adc_chan_o),
      .adc_temp_o (adc_temp_o),
      .adc_done_i (adc_done_i),
      .adc_data_i (adc_data_i),
      .clk_mode_o (clk_mode_o)
   );

   ascs_host u_ascs_host (
      .clk_i (core_clk_i),
      .dout_i(dout_o),
      .cs_n_o(cs_n_i),
      .sclk_o(sclk_i),
      .din_o (din_i)
   );

   // 25 MHz core clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // converter answers three cycles after a start; results tagged by channel
   always @(negedge core_clk_i)
   begin
      adc_done_i <= 1'b0;
      if (dly == 3'h1)
      begin
         adc_done_i <= 1'b1;
         adc_data_i <= res;
         exp_q.push_back(res);
      end
      if (dly != 3'h0)
         dly <= dly - 3'h1;
      if (adc_start_o)
      begin
         dly <= 3'h3;
         res <= {adc_temp_o ? 4'hF : adc_chan_o, seq};
         seq <= seq + 8'h01;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // bounded wait for conversion done
   task automatic wait_eoc();
      for (int i = 0; i < 3000 && eoc_n_o !== 1'b0; i++)
         @(negedge core_clk_i);
      if (eoc_n_o !== 1'b0)
      begin
         n_mismatch++;
         $display("ERROR %0t: conversion done never came", $time);
         summarize();
      end
   endtask

   // one byte in a frame of its own
   task automatic put(input logic [7:0] b);
      u_ascs_host.frame_on();
      u_ascs_host.shift({b, 8'h00}, 8, rx);
      u_ascs_host.frame_off();
   endtask

   // n result bits in a frame of their own
   task automatic get(input int n);
      u_ascs_host.frame_on();
      u_ascs_host.shift(16'h0000, n, rx);
      u_ascs_host.frame_off();
   endtask

   // main sequence
   initial
   begin
      rst_i      = 1'b1;
      adc_done_i = 1'b0;
      adc_data_i = 12'h000;
      dly        = 3'h0;
      seq        = 8'h00;
      n_mismatch = 0;
      checks     = 0;
      repeat (20) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk({14'h0, clk_mode_o}, 16'h0002);
      chk({15'h0, eoc_n_o}, 16'h0001);
      // single channel scan; done low until chip select falls
      put(8'h96);
      wait_eoc();
      u_ascs_host.frame_on();
      chk({15'h0, eoc_n_o}, 16'h0001);
      chk({15'h0, dout_oe_o}, 16'h0001);
      u_ascs_host.shift(16'h0000, 16, rx);
      u_ascs_host.frame_off();
      e = {4'h0, exp_q.pop_front()};
      chk(rx, e);
      // temperature leads the scan
      put(8'h8F);
      wait_eoc();
      get(16);
      chk({12'h0, rx[11:8]}, 16'h000F);
      chk(rx, {4'h0, exp_q.pop_front()});
      get(16);
      chk(rx, {4'h0, exp_q.pop_front()});
      // four repeats, read with cut-short frames
      put(8'h9C);
      wait_eoc();
      get(3);
      get(8);
      e = {4'h0, exp_q.pop_front()};
      chk(rx, {8'h00, e[12:5]});
      get(16);
      chk(rx, {4'h0, exp_q.pop_front()});
      get(12);
      e = {4'h0, exp_q.pop_front()};
      chk(rx, {4'h0, e[15:4]});
      get(16);
      chk(rx, {4'h0, exp_q.pop_front()});
      // serial-clocked mode; scan code of four repeats gives one result
      put(8'h70);
      chk({14'h0, clk_mode_o}, 16'h0003);
      u_ascs_host.frame_on();
      u_ascs_host.shift(16'hAC00, 8, rx);
      u_ascs_host.shift(16'h0000, 16, rx);
      u_ascs_host.frame_off();
      chk(rx, {4'h0, exp_q.pop_front()});
      repeat (60) @(negedge core_clk_i);
      chk(16'(exp_q.size()), 16'h0000);
      // temperature in serial-clocked mode: 24 zero bytes, result in last two
      u_ascs_host.frame_on();
      u_ascs_host.shift(16'h8100, 8, rx);
      repeat (22) u_ascs_host.shift(16'h0000, 8, rx);
      u_ascs_host.shift(16'h0000, 16, rx);
      u_ascs_host.frame_off();
      chk({12'h0, rx[11:8]}, 16'h000F);
      chk(rx, {4'h0, exp_q.pop_front()});
      // partial write: three bits land, upper mode bit cleared, lower kept, mode 3 becomes 1
      u_ascs_host.frame_on();
      u_ascs_host.shift(16'h4000, 3, rx);
      u_ascs_host.frame_off();
      chk({14'h0, clk_mode_o}, 16'h0001);
      put(8'h96);
      repeat (60) @(negedge core_clk_i);
      chk({15'h0, eoc_n_o}, 16'h0001);
      put(8'h60);
      chk({14'h0, clk_mode_o}, 16'h0002);
      summarize();
   end
endmodule
`default_nettype wire
